// ===== design/ssr_pkg.sv
// Shared constants and types for the converter serial readout link.
`default_nettype none
package ssr_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int WORD_BITS = 16;
    localparam int CLK_PERIOD_NS = 20;

    // Longest conversion time; the device finishes within it, so it rounds
    // down to whole clock cycles.
    localparam int CONV_MAX_NS = 710;
    localparam int CONV_CYCLES = CONV_MAX_NS / CLK_PERIOD_NS;
    localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);

    // Host wait after the trigger edge: conversion plus pin sync slack.
    localparam int SYNC_SLACK_CYCLES = 6;
    localparam logic [5:0] WAIT_LAST =
        6'(CONV_CYCLES + SYNC_SLACK_CYCLES - 1);

    // Host settle time between output enable and the first shift edge.
    localparam logic [5:0] SETTLE_LAST = 6'h07;

    // Host shift clock half period, made by dividing the system clock.
    localparam int SCK_HALF_NS = 160;
    localparam int SCK_HALF_CYCLES = SCK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [5:0] SCK_HALF_LAST = 6'(SCK_HALF_CYCLES - 1);

    // Falling shift edges in one result word; also the chain delay.
    localparam logic [4:0] WORD_EDGES = 5'h10;

    // Pin positions inside the device input synchroniser vector.
    localparam int PIN_TRIG = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_COUNT = 3;

    // Values after reset.
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [5:0] CNT_RST = 6'h00;
    localparam logic [7:0] BITS_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic {
        SSR_MODE_CHAIN = 1'b0,
        SSR_MODE_SELECT = 1'b1
    } ssr_mode_t;

    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_CONV = 2'b01,
        DEV_LOAD = 2'b11
    } ssr_dev_state_t;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_ARM = 3'b001,
        HOST_WAIT = 3'b011,
        HOST_ENA = 3'b010,
        HOST_HIGH = 3'b110,
        HOST_LOW = 3'b111,
        HOST_FIN = 3'b101
    } ssr_host_state_t;

endpackage : ssr_pkg
`default_nettype wire

// ===== design/ssr_link_if.sv
// Link wires between the host controller and the converter readout.
`timescale 1ns/10ps
`default_nettype none
interface ssr_link_if;

    logic conv_trigger;
    logic shift_clk;
    logic chain_in_select;
    logic result_out;
    logic result_out_oe_n;
    wire result_line;

    // Shared output wire; a pull-up holds it high while it is released.
    assign result_line = result_out_oe_n ? 1'b1 : result_out;

    modport dev (
        input conv_trigger,
        input shift_clk,
        input chain_in_select,
        output result_out,
        output result_out_oe_n
    );

    modport host (
        output conv_trigger,
        output shift_clk,
        output chain_in_select,
        input result_line
    );

endinterface : ssr_link_if
`default_nettype wire

// ===== design/ssr_device_end.sv
// Converter end of the serial readout link: conversion timing and shifter.
`timescale 1ns/10ps
`default_nettype none

// What this block and the host end do
// R1: Trigger rising edge starts a new conversion.
// R2: Select line low at trigger: chain mode.
// R3: Select line high at trigger: select mode.
// R4: Select mode: output enabled when either input low, until all 16 bits of the loaded word are out.
// R5: Chain mode: host holds trigger high during readout.
// R6: Host clocks; result shifts out with that clock.
// R7: Chain mode: input reappears after 16 shift clocks.
// R8: Chain input takes upstream output, words concatenate.
// R9: Result is a two's-complement word, zero midscale.
// R10: Host waits the conversion time before reading.
// R11: Most significant bit valid once output enabled.
// R12: Output advances on each shift clock falling edge.
// R13: Conversion runs on internal clock, no shifting needed.
// R14: Select mode: output released when not enabled.
// R15: Host reads MSB first, 16 bits per converter.
module ssr_device_end (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [15:0] sample_i,
    output logic conv_busy_o,
    output logic conv_done_o,
    output logic select_mode_o,
    ssr_link_if.dev link
);

    ////////////////////////////////////////////////////////////////////////
    // Rising edge of a synchronised level against its previous value.
    function automatic logic is_rise(input logic now_v, input logic prev_v);
        is_rise = now_v & ~prev_v;
    endfunction : is_rise

    ////////////////////////////////////////////////////////////////////////
    logic [ssr_pkg::PIN_COUNT-1:0] pin_raw;
    logic [ssr_pkg::PIN_COUNT-1:0] pin_meta_reg;
    logic [ssr_pkg::PIN_COUNT-1:0] pin_sync_reg;
    logic [ssr_pkg::PIN_COUNT-1:0] pin_prev_reg;

    ssr_pkg::ssr_dev_state_t state_reg;
    ssr_pkg::ssr_dev_state_t state_next;
    ssr_pkg::ssr_mode_t mode_reg;
    ssr_pkg::ssr_mode_t mode_next;
    logic [5:0] conv_cnt_reg;
    logic [5:0] conv_cnt_next;
    logic [15:0] sample_reg;
    logic [15:0] sample_next;
    logic [15:0] shreg_reg;
    logic [15:0] shreg_next;
    logic [4:0] fall_cnt_reg;
    logic [4:0] fall_cnt_next;
    logic out_reg;
    logic oe_n_reg;
    logic busy_reg;
    logic done_reg;

    assign pin_raw[ssr_pkg::PIN_TRIG] = link.conv_trigger;
    assign pin_raw[ssr_pkg::PIN_SCK] = link.shift_clk;
    assign pin_raw[ssr_pkg::PIN_SEL] = link.chain_in_select;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every link pin; the meta stage feeds only
    // the sync stage.
    genvar gi;
    generate
        for (gi = 0; gi < ssr_pkg::PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge clock_i) begin
                if (rst_i) begin
                    pin_meta_reg[gi] <= 1'b0;
                    pin_sync_reg[gi] <= 1'b0;
                    pin_prev_reg[gi] <= 1'b0;
                end else begin
                    pin_meta_reg[gi] <= pin_raw[gi];
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                    pin_prev_reg[gi] <= pin_sync_reg[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    wire trig_lvl = pin_sync_reg[ssr_pkg::PIN_TRIG];
    wire sel_lvl = pin_sync_reg[ssr_pkg::PIN_SEL];
    wire trig_rise = is_rise(trig_lvl, pin_prev_reg[ssr_pkg::PIN_TRIG]);
    wire sck_fall = is_rise(~pin_sync_reg[ssr_pkg::PIN_SCK],
                            ~pin_prev_reg[ssr_pkg::PIN_SCK]);
    wire is_select = (mode_reg == ssr_pkg::SSR_MODE_SELECT);
    wire word_out_done = (fall_cnt_reg == ssr_pkg::WORD_EDGES);
    // Either input low enables; after the last bit the line is released.
    wire sel_enabled = (~trig_lvl | ~sel_lvl) & ~word_out_done; // [R4]
    wire conv_end = (state_reg == ssr_pkg::DEV_CONV) &
                    (conv_cnt_reg == ssr_pkg::CONV_LAST);
    wire load_word = (state_reg == ssr_pkg::DEV_LOAD);
    wire oe_n_next = is_select ? ~sel_enabled : 1'b0; // [R14]
    wire out_next = shreg_reg[ssr_pkg::WORD_BITS-1]; // [R11]

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer; it counts system clocks only, so a conversion
    // completes even while the shift clock stands still.
    always_comb begin
        state_next = state_reg;
        conv_cnt_next = conv_cnt_reg;
        mode_next = mode_reg;
        sample_next = sample_reg;
        if (trig_rise) begin
            // A new edge restarts the conversion and re-reads the mode.
            state_next = ssr_pkg::DEV_CONV; // [R1]
            conv_cnt_next = ssr_pkg::CNT_RST;
            sample_next = sample_i; // [R1]
            mode_next = sel_lvl ? ssr_pkg::SSR_MODE_SELECT
                                : ssr_pkg::SSR_MODE_CHAIN; // [R2] [R3]
        end else begin
            case (state_reg)
                ssr_pkg::DEV_IDLE: begin
                    conv_cnt_next = ssr_pkg::CNT_RST;
                end
                ssr_pkg::DEV_CONV: begin
                    conv_cnt_next = conv_cnt_reg + 6'h01; // [R13]
                    if (conv_end) begin
                        state_next = ssr_pkg::DEV_LOAD;
                    end
                end
                ssr_pkg::DEV_LOAD: begin
                    state_next = ssr_pkg::DEV_IDLE;
                end
                default: begin
                    state_next = ssr_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter. A fresh result wins over a shift edge in the same
    // cycle.
    always_comb begin
        shreg_next = shreg_reg;
        fall_cnt_next = fall_cnt_reg;
        if (load_word) begin
            // The code goes out as is: two's complement, zero at midscale.
            shreg_next = sample_reg; // [R9]
            fall_cnt_next = 5'h00;
        end else if (sck_fall) begin
            if (!is_select) begin
                // Upstream data enters the bottom and leaves the top after
                // a full word of edges.
                shreg_next = {shreg_reg[14:0], sel_lvl}; // [R7] [R8] [R12]
            end else if (sel_enabled) begin
                shreg_next = {shreg_reg[14:0], 1'b0}; // [R6] [R12]
                fall_cnt_next = fall_cnt_reg + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg <= ssr_pkg::DEV_IDLE;
            mode_reg <= ssr_pkg::SSR_MODE_SELECT;
            conv_cnt_reg <= ssr_pkg::CNT_RST;
            sample_reg <= ssr_pkg::WORD_RST;
        end else begin
            state_reg <= state_next;
            mode_reg <= mode_next;
            conv_cnt_reg <= conv_cnt_next;
            sample_reg <= sample_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            shreg_reg <= ssr_pkg::WORD_RST;
            fall_cnt_reg <= ssr_pkg::WORD_EDGES;
        end else begin
            shreg_reg <= shreg_next;
            fall_cnt_reg <= fall_cnt_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            busy_reg <= (state_next == ssr_pkg::DEV_CONV);
            done_reg <= conv_end & ~trig_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.result_out = out_reg;
    assign link.result_out_oe_n = oe_n_reg;
    assign conv_busy_o = busy_reg;
    assign conv_done_o = done_reg;
    assign select_mode_o = mode_reg;

endmodule : ssr_device_end
`default_nettype wire

// ===== design/ssr_host_end.sv
// Host end of the serial readout link: trigger, shift clock and capture.
`timescale 1ns/10ps
`default_nettype none
module ssr_host_end (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic chain_mode_i,
    input wire logic [3:0] words_i,
    output logic busy_o,
    output logic [15:0] word_o,
    output logic word_valid_o,
    ssr_link_if.host link
);

    ////////////////////////////////////////////////////////////////////////
    ssr_pkg::ssr_host_state_t state_reg;
    ssr_pkg::ssr_host_state_t state_next;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [7:0] bits_reg;
    logic [7:0] bits_next;
    logic [7:0] total_reg;
    logic [7:0] total_next;
    logic chain_reg;
    logic chain_next;
    logic trig_reg;
    logic trig_next;
    logic sck_reg;
    logic sck_next;
    logic sel_reg;
    logic sel_next;
    logic busy_reg;
    logic busy_next;
    logic [15:0] word_sh_reg;
    logic [15:0] word_sh_next;
    logic [15:0] word_reg;
    logic [15:0] word_next;
    logic valid_reg;
    logic valid_next;
    logic line_meta_reg;
    logic line_sync_reg;

    wire [3:0] words_eff = (words_i == 4'h0) ? 4'h1 : words_i;
    wire [7:0] total_req = chain_mode_i ? {words_eff, 4'h0} : 8'h10; // [R15]
    wire [15:0] word_shifted = {word_sh_reg[14:0], line_sync_reg};
    wire half_done = (cnt_reg == ssr_pkg::SCK_HALF_LAST);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 6'h01;
        bits_next = bits_reg;
        total_next = total_reg;
        chain_next = chain_reg;
        trig_next = trig_reg;
        sck_next = sck_reg;
        sel_next = sel_reg;
        busy_next = busy_reg;
        word_sh_next = word_sh_reg;
        word_next = word_reg;
        valid_next = 1'b0;
        case (state_reg)
            ssr_pkg::HOST_IDLE: begin
                cnt_next = ssr_pkg::CNT_RST;
                if (start_i) begin
                    chain_next = chain_mode_i;
                    total_next = total_req;
                    // Mode level is set a cycle ahead of the trigger edge.
                    sel_next = ~chain_mode_i; // [R2] [R3]
                    busy_next = 1'b1;
                    state_next = ssr_pkg::HOST_ARM;
                end
            end
            ssr_pkg::HOST_ARM: begin
                trig_next = 1'b1;
                cnt_next = ssr_pkg::CNT_RST;
                state_next = ssr_pkg::HOST_WAIT;
            end
            ssr_pkg::HOST_WAIT: begin
                if (cnt_reg == ssr_pkg::WAIT_LAST) begin // [R10]
                    cnt_next = ssr_pkg::CNT_RST;
                    // Chain mode keeps the trigger high for the readout.
                    trig_next = chain_reg; // [R4] [R5]
                    state_next = ssr_pkg::HOST_ENA;
                end
            end
            ssr_pkg::HOST_ENA: begin
                if (cnt_reg == ssr_pkg::SETTLE_LAST) begin
                    cnt_next = ssr_pkg::CNT_RST;
                    bits_next = ssr_pkg::BITS_RST;
                    sck_next = 1'b1; // [R6]
                    state_next = ssr_pkg::HOST_HIGH;
                end
            end
            ssr_pkg::HOST_HIGH: begin
                if (half_done) begin
                    // Sample just before the falling edge moves the bit.
                    cnt_next = ssr_pkg::CNT_RST;
                    sck_next = 1'b0;
                    word_sh_next = word_shifted; // [R15]
                    bits_next = bits_reg + 8'h01;
                    if (bits_reg[3:0] == 4'hF) begin // [R8] [R15]
                        word_next = word_shifted;
                        valid_next = 1'b1;
                    end
                    state_next = ssr_pkg::HOST_LOW;
                end
            end
            ssr_pkg::HOST_LOW: begin
                if (half_done) begin
                    cnt_next = ssr_pkg::CNT_RST;
                    if (bits_reg == total_reg) begin
                        state_next = ssr_pkg::HOST_FIN;
                    end else begin
                        sck_next = 1'b1; // [R6]
                        state_next = ssr_pkg::HOST_HIGH;
                    end
                end
            end
            ssr_pkg::HOST_FIN: begin
                trig_next = 1'b0;
                sel_next = 1'b1;
                busy_next = 1'b0;
                state_next = ssr_pkg::HOST_IDLE;
            end
            default: begin
                state_next = ssr_pkg::HOST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            line_meta_reg <= 1'b0;
            line_sync_reg <= 1'b0;
        end else begin
            line_meta_reg <= link.result_line;
            line_sync_reg <= line_meta_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_reg <= ssr_pkg::HOST_IDLE;
            cnt_reg <= ssr_pkg::CNT_RST;
            bits_reg <= ssr_pkg::BITS_RST;
            total_reg <= ssr_pkg::BITS_RST;
            chain_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bits_reg <= bits_next;
            total_reg <= total_next;
            chain_reg <= chain_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            trig_reg <= 1'b0;
            sck_reg <= 1'b0;
            sel_reg <= 1'b1;
            busy_reg <= 1'b0;
            word_sh_reg <= ssr_pkg::WORD_RST;
            word_reg <= ssr_pkg::WORD_RST;
            valid_reg <= 1'b0;
        end else begin
            trig_reg <= trig_next;
            sck_reg <= sck_next;
            sel_reg <= sel_next;
            busy_reg <= busy_next;
            word_sh_reg <= word_sh_next;
            word_reg <= word_next;
            valid_reg <= valid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.conv_trigger = trig_reg;
    assign link.shift_clk = sck_reg;
    assign link.chain_in_select = sel_reg;
    assign busy_o = busy_reg;
    assign word_o = word_reg;
    assign word_valid_o = valid_reg;

endmodule : ssr_host_end
`default_nettype wire

// ===== tb/ssr_link_properties.sv
// Concurrent checks on the wires between the host and converter ends.
`timescale 1ns/10ps
`default_nettype none
module ssr_link_properties (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic conv_trigger,
    input wire logic shift_clk,
    input wire logic chain_in_select,
    input wire logic result_out,
    input wire logic result_out_oe_n,
    input wire logic conv_busy_o,
    input wire logic conv_done_o,
    input wire logic select_mode_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    a_busy_on_rise: assert property (
        $rose(conv_trigger) |-> ##[1:6] conv_busy_o)
        else $error("busy did not follow trigger rise");
    a_done_after_rise: assert property (
        $rose(conv_trigger) |-> ##[35:42] conv_done_o)
        else $error("conversion end missing after trigger rise");
    a_busy_holds: assert property (
        $rose(conv_busy_o) |-> conv_busy_o [*8])
        else $error("conversion busy ended too early");
    a_mode_chain: assert property (
        $rose(conv_trigger) && !chain_in_select |-> ##[1:6] !select_mode_o)
        else $error("chain mode not entered");
    a_mode_select: assert property (
        $rose(conv_trigger) && chain_in_select |-> ##[1:6] select_mode_o)
        else $error("select mode not entered");
    a_chain_enabled: assert property (
        !select_mode_o && $past(select_mode_o, 3) == 1'b0
        |-> !result_out_oe_n)
        else $error("output released in chain mode");
    a_release_idle: assert property (
        (select_mode_o && conv_trigger && chain_in_select) [*6]
        |-> result_out_oe_n)
        else $error("output driven while not enabled");
    a_enable_low: assert property (
        $fell(conv_trigger) && select_mode_o && !conv_busy_o
        |-> ##[1:6] !result_out_oe_n)
        else $error("output not enabled by trigger low");
    a_shift_stable: assert property (
        $rose(shift_clk) |=> $stable(result_out) [*8])
        else $error("output moved while shift clock high");
    a_chain_trig_high: assert property (
        !select_mode_o && shift_clk |-> conv_trigger)
        else $error("trigger low during chain readout");
    a_no_read_busy: assert property (
        conv_busy_o |-> !shift_clk)
        else $error("shift clock ran during conversion");

    c_chain_start: cover property ($rose(conv_trigger) && !chain_in_select);
    c_conv_done: cover property (conv_done_o);
    c_sel_enable: cover property ($fell(result_out_oe_n) && select_mode_o);
endmodule : ssr_link_properties
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: host and converter ends joined over the link.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] sample_i = 16'h0000;
    logic start_i = 1'b0;
    logic chain_mode_i = 1'b0;
    logic [3:0] words_i = 4'h1;
    logic conv_busy_o;
    logic conv_done_o;
    logic select_mode_o;
    logic busy_o;
    logic [15:0] word_o;
    logic word_valid_o;
    int num_errors = 0;
    int check_count = 0;

    always #10 clock_i = ~clock_i;

    ssr_link_if link ();

    ssr_device_end i_ssr_device_end (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .sample_i(sample_i),
        .conv_busy_o(conv_busy_o),
        .conv_done_o(conv_done_o),
        .select_mode_o(select_mode_o),
        .link(link.dev)
    );

    ssr_host_end i_ssr_host_end (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(start_i),
        .chain_mode_i(chain_mode_i),
        .words_i(words_i),
        .busy_o(busy_o),
        .word_o(word_o),
        .word_valid_o(word_valid_o),
        .link(link.host)
    );

    ssr_link_properties i_ssr_link_properties (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .conv_trigger(link.conv_trigger),
        .shift_clk(link.shift_clk),
        .chain_in_select(link.chain_in_select),
        .result_out(link.result_out),
        .result_out_oe_n(link.result_out_oe_n),
        .conv_busy_o(conv_busy_o),
        .conv_done_o(conv_done_o),
        .select_mode_o(select_mode_o)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // Runs one host read and judges words, wire bits and shift edges.
    task automatic run_read(input logic chain, input logic [3:0] nw,
            input logic [15:0] smp, input int n_exp);
        int got_n;
        int dones;
        int falls;
        int i;
        logic prev_oe;
        logic prev_sck;
        logic [15:0] wire_word;
        got_n = 0;
        dones = 0;
        falls = 0;
        wire_word = 16'h0000;
        sample_i = smp;
        chain_mode_i = chain;
        words_i = nw;
        start_i = 1'b1;
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        prev_oe = link.result_out_oe_n;
        prev_sck = link.shift_clk;
        for (i = 0; i < 3000; i++) begin
            if (word_valid_o === 1'b1) begin
                check("word_o", (got_n == 0) ? smp : 16'h0000,
                    word_o);
                got_n++;
            end
            if (conv_done_o === 1'b1) begin
                dones++;
            end
            if (conv_busy_o === 1'b1 && link.shift_clk !== 1'b0) begin
                check("shift_clk in conversion", 16'h0000, 16'h0001);
            end
            if (!chain && prev_oe === 1'b1 && link.result_out_oe_n === 1'b0)
            begin
                check("msb on enable", {15'h0, smp[15]},
                    {15'h0, link.result_out});
            end
            if (prev_sck === 1'b1 && link.shift_clk === 1'b0) begin
                if (falls < 16) begin
                    wire_word = {wire_word[14:0], link.result_line};
                end
                falls++;
            end
            prev_oe = link.result_out_oe_n;
            prev_sck = link.shift_clk;
            if (busy_o === 1'b0) begin
                break;
            end
            @(posedge clock_i);
            #1;
        end
        if (i == 3000) begin
            num_errors++;
            $display("mismatch busy_o expected 0 seen 1");
            results();
        end
        repeat (6) @(posedge clock_i);
        #1;
        check("word count", 16'(n_exp), 16'(got_n));
        check("wire word", smp, wire_word);
        check("shift falls", 16'(16 * n_exp), 16'(falls));
        check("done pulses", 16'h0001, 16'(dones));
        check("select_mode_o", {15'h0, ~chain},
            {15'h0, select_mode_o});
    endtask : run_read

    task automatic test_select_codes();
        logic [15:0] codes [6];
        codes = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h8001,
            16'hA5C3};
        foreach (codes[k]) begin
            run_read(1'b0, 4'h1, codes[k], 1);
            check("result_line idle", 16'h0003,
                {14'h0, link.result_out_oe_n, link.result_line});
        end
        $display("test select_codes finished, mismatches %0d", num_errors);
    endtask : test_select_codes

    task automatic test_chain();
        run_read(1'b1, 4'h2, 16'hFFFF, 2);
        run_read(1'b1, 4'h3, 16'hC3A5, 3);
        run_read(1'b1, 4'h0, 16'h1234, 1);
        run_read(1'b0, 4'h2, 16'h4321, 1);
        $display("test chain finished, mismatches %0d", num_errors);
    endtask : test_chain

    // Reset in mid read must bring both ends back to their idle levels.
    task automatic test_mid_reset();
        sample_i = 16'h5A5A;
        chain_mode_i = 1'b0;
        words_i = 4'h1;
        start_i = 1'b1;
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        repeat (120) @(posedge clock_i);
        #1;
        rst_i = 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        check("reset state", 16'h001A, {8'h00, busy_o, conv_busy_o,
            conv_done_o, select_mode_o, link.result_out_oe_n,
            link.conv_trigger, link.chain_in_select, link.shift_clk});
        rst_i = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        run_read(1'b0, 4'h1, 16'h0F0F, 1);
        $display("test mid_reset finished, mismatches %0d", num_errors);
    endtask : test_mid_reset

    initial begin
        repeat (12) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        test_select_codes();
        test_chain();
        test_mid_reset();
        results();
    end
endmodule : testbench
`default_nettype wire
